// File: hw/swcc_sleep_ctrl.v
// Sleep, wake and system clock control with an AHB-Lite register slave.
// Assumes hclk is the always-on control clock; the core clock is gated by
// sysclk_run, and the core drives halt and clear pulses on hclk.
`timescale 1ns/1ps
`default_nettype none
`include "swcc_consts.vh"

module swcc_sleep_ctrl #(
  parameter PA_W    = 8,
  parameter IRQ_W   = 4,
  parameter WDT_W   = 15,
  parameter RESTART = `SWCC_RESTART_CYCLES
) (
  input  wire             hclk,
  input  wire             hresetn,
  input  wire             hsel,
  input  wire [31:0]      haddr,
  input  wire [1:0]       htrans,
  input  wire             hwrite,
  input  wire [2:0]       hsize,
  input  wire [31:0]      hwdata,
  input  wire             hready,
  output wire             hreadyout,
  output wire             hresp,
  output reg  [31:0]      hrdata,
  input  wire             halt_exec,
  input  wire             clr_wdt_exec,
  input  wire [IRQ_W-1:0] irq_req,
  input  wire [IRQ_W-1:0] irq_en,
  input  wire             stack_full,
  input  wire             rst_pin_n,
  input  wire [PA_W-1:0]  porta_pin,
  input  wire             wdt_osc_pin,
  output wire             sysclk_run,
  output wire             core_run,
  output reg              full_reset_pulse,
  output reg              pc_sp_reset_pulse,
  output reg              resume_next_pulse,
  output reg              irq_service_pulse,
  output reg  [IRQ_W-1:0] irq_wake_vec,
  output wire             wdt_osc_run,
  output reg              sleep_entered_flag,
  output reg              watchdog_expired_flag,
  output reg              clock_out_shared_pin_o,
  output reg              clock_out_shared_pin_oe
);

  localparam S_RUN     = `SWCC_S_RUN;
  localparam S_SLEEP   = `SWCC_S_SLEEP;
  localparam S_RESTART = `SWCC_S_RESTART;
  localparam S_IRQ_GAP = `SWCC_S_IRQ_GAP;
  localparam RW        = 11;

  // ****************************************
  // Register bus slave
  // ****************************************
  reg  [31:0] cfg_reg;
  reg         wr_pend_reg;
  reg  [7:0]  wr_addr_reg;
  wire        addr_phase = hsel & hready & htrans[1];

  function is_ofs;
    input [31:0] a;
    input [7:0]  ofs;
    begin
      is_ofs = (a[31:8] == 24'h00_0000) && (a[7:0] == ofs);
    end
  endfunction

  // Zero wait state, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ****************************************
  // Configuration decode
  // ****************************************
  wire [1:0]      osc_mode   = cfg_reg[`SWCC_CFG_OSC_MSB:`SWCC_CFG_OSC_LSB];
  wire            wdt_en     = cfg_reg[`SWCC_CFG_WDT_EN];
  wire            wdtosc_en  = cfg_reg[`SWCC_CFG_WDTOSC_EN];
  wire            wdt_sys    = cfg_reg[`SWCC_CFG_WDT_SYS];
  wire [PA_W-1:0] pa_wake_en = cfg_reg[`SWCC_CFG_PAWK_LSB +: PA_W];

  // ****************************************
  // Pin synchronisers
  // ****************************************
  wire [PA_W+1:0] pin_lvl;
  wire [PA_W+1:0] pin_fall;

  swcc_pin_sync #(
    .W (PA_W + 2)
  ) swcc_pin_sync_i (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin_in  ({rst_pin_n, wdt_osc_pin, porta_pin}),
    .level   (pin_lvl),
    .fall    (pin_fall)
  );

  wire rst_pin_act = ~pin_lvl[PA_W+1];
  wire wdt_osc_edge = pin_fall[PA_W];
  wire [PA_W-1:0] pa_fall = pin_fall[PA_W-1:0];

  // ****************************************
  // State and counters
  // ****************************************
  reg [1:0]       state_reg;
  reg [1:0]       state_next;
  reg [1:0]       cause_reg;
  reg [RW-1:0]    delay_reg;
  reg [1:0]       div_reg;
  reg [WDT_W-1:0] wdt_cnt_reg;
  reg [IRQ_W-1:0] irq_arm_reg;
  reg             rst_prev_reg;

  wire sleeping = (state_reg == S_SLEEP);

  assign sysclk_run = ~sleeping;
  assign core_run   = (state_reg == S_RUN);
  assign wdt_osc_run = wdtosc_en;

  wire halt_take = halt_exec & (state_reg == S_RUN);

  wire [IRQ_W-1:0] irq_wake = irq_req & irq_arm_reg;
  wire pa_wake = |(pa_fall & pa_wake_en);

  wire wdt_tick = wdt_sys ? (sysclk_run & (div_reg == 2'h3))
                          : (wdtosc_en & wdt_osc_edge);
  wire wdt_ovf  = wdt_en & wdt_tick & (&wdt_cnt_reg);
  wire rst_edge = rst_pin_act & ~rst_prev_reg;

  // ****************************************
  // Next state
  // ****************************************
  always @* begin
    state_next = state_reg;
    case (state_reg)
      S_RUN: begin
        if (halt_take) begin
          state_next = S_SLEEP;
        end
      end
      S_SLEEP: begin
        if (rst_pin_act | wdt_ovf | (|irq_wake) | pa_wake) begin
          state_next = S_RESTART;
        end
      end
      S_RESTART: begin
        if (delay_reg == RESTART[RW-1:0] - 1'b1) begin
          if ((cause_reg == `SWCC_W_IRQ) && !stack_full &&
              (|(irq_wake_vec & irq_en))) begin
            state_next = S_IRQ_GAP;
          end else begin
            state_next = S_RUN;
          end
        end
      end
      S_IRQ_GAP: begin
        state_next = S_RUN;
      end
      default: begin
        state_next = S_RUN;
      end
    endcase
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg         <= S_RUN;
      cause_reg         <= `SWCC_W_RESET;
      delay_reg         <= {RW{1'b0}};
      irq_arm_reg       <= {IRQ_W{1'b0}};
      irq_wake_vec      <= {IRQ_W{1'b0}};
      full_reset_pulse  <= 1'b0;
      pc_sp_reset_pulse <= 1'b0;
      resume_next_pulse <= 1'b0;
      irq_service_pulse <= 1'b0;
      rst_prev_reg      <= 1'b0;
    end else begin
      state_reg         <= state_next;
      rst_prev_reg      <= rst_pin_act;
      full_reset_pulse  <= 1'b0;
      pc_sp_reset_pulse <= 1'b0;
      resume_next_pulse <= 1'b0;
      irq_service_pulse <= 1'b0;
      if (halt_take) begin
        irq_arm_reg <= ~irq_req;
      end
      // Reset pin while running resets the core at once
      if (core_run && rst_edge) begin
        full_reset_pulse <= 1'b1;
      end
      if (sleeping && state_next == S_RESTART) begin
        delay_reg <= {RW{1'b0}};
        irq_wake_vec <= irq_wake;
        if (rst_pin_act) begin
          cause_reg <= `SWCC_W_RESET;
        end else if (wdt_ovf) begin
          cause_reg <= `SWCC_W_WDT;
        end else if (|irq_wake) begin
          cause_reg <= `SWCC_W_IRQ;
        end else begin
          cause_reg <= `SWCC_W_PORTA;
        end
      end
      if (state_reg == S_RESTART) begin
        delay_reg <= delay_reg + 1'b1;
        if (state_next == S_RUN) begin
          case (cause_reg)
            `SWCC_W_RESET: full_reset_pulse <= 1'b1;
            `SWCC_W_WDT: pc_sp_reset_pulse <= 1'b1;
            default: resume_next_pulse <= 1'b1;
          endcase
        end
      end
      if (state_reg == S_IRQ_GAP) begin
        irq_service_pulse <= 1'b1;
      end
    end
  end

  // ****************************************
  // Watchdog counter and flags
  // ****************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdt_cnt_reg           <= {WDT_W{1'b0}};
      sleep_entered_flag    <= 1'b0;
      watchdog_expired_flag <= 1'b0;
    end else begin
      if (halt_take || clr_wdt_exec || rst_pin_act || !wdt_en) begin
        wdt_cnt_reg <= {WDT_W{1'b0}};
      end else if (wdt_tick) begin
        wdt_cnt_reg <= wdt_cnt_reg + 1'b1;
      end
      if (clr_wdt_exec && core_run) begin
        sleep_entered_flag <= 1'b0;
      end
      if (halt_take) begin
        sleep_entered_flag    <= 1'b1;
        watchdog_expired_flag <= 1'b0;
      end
      if (wdt_ovf) begin
        watchdog_expired_flag <= 1'b1;
      end
    end
  end

  // ****************************************
  // Clock divider and shared pin
  // ****************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_reg                 <= 2'h0;
      clock_out_shared_pin_o  <= 1'b0;
      clock_out_shared_pin_oe <= 1'b0;
    end else begin
      if (sysclk_run) begin
        div_reg <= div_reg + 1'b1;
      end
      clock_out_shared_pin_o  <= div_reg[1];
      clock_out_shared_pin_oe <= (osc_mode == `SWCC_OSC_RC_CLKOUT);
    end
  end

  // ****************************************
  // Register access
  // ****************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_reg     <= `SWCC_CFG_RST;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata      <= 32'h0000_0000;
    end else begin
      // Full decode, so writes outside the map cannot alias onto the config word
      wr_pend_reg <= addr_phase & hwrite & is_ofs(haddr, `SWCC_CFG_OFS);
      if (addr_phase) begin
        wr_addr_reg <= haddr[7:0];
      end
      if (wr_pend_reg && wr_addr_reg == `SWCC_CFG_OFS) begin
        cfg_reg <= hwdata;
      end
      if (addr_phase && !hwrite) begin
        if (is_ofs(haddr, `SWCC_CFG_OFS)) begin
          hrdata <= cfg_reg;
        end else if (is_ofs(haddr, `SWCC_STATUS_OFS)) begin
          hrdata <= {26'h000_0000, cause_reg, state_reg,
                     watchdog_expired_flag, sleep_entered_flag};
        end else if (is_ofs(haddr, `SWCC_WDTCNT_OFS)) begin
          hrdata <= {{(32-WDT_W){1'b0}}, wdt_cnt_reg};
        end else begin
          hrdata <= 32'h0000_0000;
        end
      end
    end
  end

endmodule // swcc_sleep_ctrl

`default_nettype wire

// File: hw/swcc_consts.vh
// Constants for the sleep, wake and clock control block: register offsets,
// field positions, reset values, state and cause codes, timing counts.
// Assumes inclusion by bare name from the design files under hw/.
//
// Behaviour
// - System clock is crystal or RC by configuration; crystal has a 10MHz range bit.
// - In RC mode, clock divided by 4 drives the shared pin only when selected.
// - Watchdog oscillator free-runs apart from the system clock, also during sleep.
// - A configuration bit can switch the watchdog oscillator off entirely.
// - Only the halt instruction puts the device to sleep.
// - Halt stops the system oscillator and freezes execution at the halt.
// - Memory, registers and port states are held unchanged during sleep.
// - Halt clears the watchdog; it runs on its oscillator, stops on system clock.
// - Halt sets the sleep-entered flag and clears the watchdog-expired flag (here a watchdog overflow in the halt cycle sets it instead).
// - Sleep ends on reset pin, port A falling edge, interrupt or watchdog overflow.
// - Reset pin wake gives full reset; watchdog wake gives watchdog reset.
// - Sleep-entered flag cleared by power-up or watchdog clear, set by halt.
// - Watchdog time-out sets expired flag; its wake resets only PC and stack.
// - Each port A pin is wake-enabled alone; its wake resumes after halt.
// - Disabled or stack-full interrupt wake resumes after halt, request stays pending.
// - Enabled interrupt with stack room wakes into the normal interrupt response.
// - An interrupt already requesting when sleep starts cannot wake the device.
// - Every wake waits 1024 system clock periods before running again.
// - Serviced interrupt routine starts one or more cycles after the delay.
// - Resume-after-halt runs the next instruction right when the delay ends.
// - Watchdog reset in sleep leaves both flags reading one.
`ifndef SWCC_CONSTS_VH
`define SWCC_CONSTS_VH

// ****************************************
// Register offsets
// ****************************************
`define SWCC_CFG_OFS       8'h00
`define SWCC_STATUS_OFS    8'h04
`define SWCC_WDTCNT_OFS    8'h08

// ****************************************
// Configuration fields
// ****************************************
`define SWCC_CFG_OSC_LSB   0
`define SWCC_CFG_OSC_MSB   1
`define SWCC_CFG_XTAL_HI   2
`define SWCC_CFG_WDT_EN    3
`define SWCC_CFG_WDTOSC_EN 4
`define SWCC_CFG_WDT_SYS   5
`define SWCC_CFG_PAWK_LSB  8
`define SWCC_CFG_RST       32'h0000_0018

`define SWCC_OSC_XTAL      2'h0
`define SWCC_OSC_RC_CLKOUT 2'h1
`define SWCC_OSC_RC_IO     2'h2

// ****************************************
// Status fields
// ****************************************
`define SWCC_ST_SLEEP      0
`define SWCC_ST_EXPIRED    1
`define SWCC_ST_STATE_LSB  2
`define SWCC_ST_CAUSE_LSB  4

// ****************************************
// States and wake causes
// ****************************************
`define SWCC_S_RUN         2'h0
`define SWCC_S_SLEEP       2'h1
`define SWCC_S_RESTART     2'h2
`define SWCC_S_IRQ_GAP     2'h3

`define SWCC_W_RESET       2'h0
`define SWCC_W_WDT         2'h1
`define SWCC_W_IRQ         2'h2
`define SWCC_W_PORTA       2'h3

// ****************************************
// Timing
// ****************************************
`define SWCC_RESTART_CYCLES 1024
`define SWCC_IRQ_GAP_CYCLES 1
`define SWCC_CLK_DIV        4

`endif

// File: hw/swcc_pin_sync.v
// Two-flop synchronisers with falling-edge and level outputs for pins.
// Assumes pins are asynchronous to hclk; hclk keeps running in sleep.
`timescale 1ns/1ps
`default_nettype none

module swcc_pin_sync #(
  parameter W = 10
) (
  input  wire         hclk,
  input  wire         hresetn,
  input  wire [W-1:0] pin_in,
  output wire [W-1:0] level,
  output wire [W-1:0] fall
);

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      // One driver per register: each bit keeps its own flops
      reg meta_reg;
      reg sync_reg;
      reg prev_reg;
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          meta_reg <= 1'b1;
          sync_reg <= 1'b1;
          prev_reg <= 1'b1;
        end else begin
          meta_reg <= pin_in[i];
          sync_reg <= meta_reg;
          prev_reg <= sync_reg;
        end
      end
      assign level[i] = sync_reg;
      assign fall[i]  = prev_reg & ~sync_reg;
    end
  endgenerate

endmodule // swcc_pin_sync

`default_nettype wire

// File: tb/swcc_sleep_ctrl_assertions.sv
// Checker for the sleep controller: sleep entry, restart delay, wake pulses.
// Assumes binding to swcc_sleep_ctrl; RESTART follows the bound instance.
`timescale 1ns/1ps
`default_nettype none

module swcc_sleep_ctrl_assertions #(
  parameter int RESTART = 1024
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic halt_exec,
  input wire logic clr_wdt_exec,
  input wire logic rst_pin_n,
  input wire logic sysclk_run,
  input wire logic core_run,
  input wire logic full_reset_pulse,
  input wire logic pc_sp_reset_pulse,
  input wire logic resume_next_pulse,
  input wire logic irq_service_pulse,
  input wire logic sleep_entered_flag,
  input wire logic watchdog_expired_flag,
  input wire logic clock_out_shared_pin_o,
  input wire logic clock_out_shared_pin_oe
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Restart cycles since the oscillator came back; cleared while asleep
  logic [11:0] off_cnt;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) off_cnt <= 12'h000;
    else if (!sysclk_run) off_cnt <= 12'h000;
    else if (!core_run) off_cnt <= off_cnt + 12'h001;

  // Cycles since the reset pin fell, until the full reset answers; saturates so a
  // missing answer keeps the count high instead of wrapping back into range
  logic [11:0] rst_wait;
  logic        rst_pin_q;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) begin
      rst_pin_q <= 1'b1;
      rst_wait  <= 12'h000;
    end else begin
      rst_pin_q <= rst_pin_n;
      if (full_reset_pulse) rst_wait <= 12'h000;
      else if (rst_pin_q && !rst_pin_n) rst_wait <= 12'h001;
      else if (rst_wait != 12'h000 && rst_wait != 12'hfff) rst_wait <= rst_wait + 12'h001;
    end

  AST_ONLY_HALT: assert property ($fell(sysclk_run) |-> $past(halt_exec) && $past(core_run))
    else $error("sleep entered without halt");
  AST_HALT_STOPS: assert property (halt_exec && core_run |=> !sysclk_run && !core_run)
    else $error("halt did not stop oscillator and core");
  AST_FLAG_SET: assert property ($rose(sleep_entered_flag) |-> $past(halt_exec))
    else $error("sleep flag set without halt");
  AST_FLAG_CLR: assert property (clr_wdt_exec && !halt_exec && core_run |=> !sleep_entered_flag)
    else $error("watchdog clear left sleep flag set");
  AST_RESTART_LEN: assert property ($rose(core_run) && !irq_service_pulse |-> off_cnt == RESTART)
    else $error("restart delay length wrong");
  AST_IRQ_GAP: assert property (irq_service_pulse |-> $rose(core_run) && off_cnt == RESTART + 1)
    else $error("interrupt start not one cycle after delay");
  AST_RESUME_NOW: assert property (resume_next_pulse |-> $rose(core_run))
    else $error("resume not at end of delay");
  AST_ONE_CAUSE: assert property ($onehot0({full_reset_pulse, pc_sp_reset_pulse,
                                   resume_next_pulse, irq_service_pulse}))
    else $error("several wake actions at once");
  AST_WDT_FLAGS: assert property (pc_sp_reset_pulse |-> sleep_entered_flag && watchdog_expired_flag)
    else $error("watchdog wake flags wrong");
  AST_PIN_RESET: assert property (rst_wait <= RESTART + 8)
    else $error("reset pin gave no full reset");
  AST_CLK_DIV: assert property (clock_out_shared_pin_oe && $past(clock_out_shared_pin_oe, 2) &&
                                $past(sysclk_run, 2) && $past(sysclk_run, 3)
                                |-> clock_out_shared_pin_o != $past(clock_out_shared_pin_o, 2))
    else $error("clock output not divided by four");
endmodule // swcc_sleep_ctrl_assertions

bind swcc_sleep_ctrl swcc_sleep_ctrl_assertions #(.RESTART(RESTART)) swcc_chk_i (.*);

`default_nettype wire

// File: tb/swcc_core_model.sv
// Core and wake-source model: halt and clear pulses, interrupts, pins, watchdog oscillator.
// Assumes the bench steers its variables right after rising edges of hclk.
`timescale 1ns/1ps
`default_nettype none

module swcc_core_model (
  input  wire logic       hclk,
  input  wire logic       wdt_osc_run,
  output var  logic       halt_exec,
  output var  logic       clr_wdt_exec,
  output var  logic [3:0] irq_req,
  output var  logic [3:0] irq_en,
  output var  logic       stack_full,
  output var  logic       rst_pin_n,
  output var  logic [7:0] porta_pin,
  output var  logic       wdt_osc_pin
);
  logic [1:0] osc_div;

  initial begin
    {halt_exec, clr_wdt_exec, stack_full, osc_div} = 5'h00;
    {irq_req, irq_en} = 8'h00;
    {rst_pin_n, porta_pin, wdt_osc_pin} = 10'h3fe;
  end

  // free-running oscillator, stands still when switched off
  always @(posedge hclk) begin
    if (wdt_osc_run) begin
      osc_div <= osc_div + 2'h1;
      wdt_osc_pin <= osc_div[1];
    end
  end

  task automatic do_pulse(input logic halt);
    @(posedge hclk);
    if (halt) halt_exec <= 1'b1;
    else clr_wdt_exec <= 1'b1;
    @(posedge hclk);
    {halt_exec, clr_wdt_exec} <= 2'h0;
  endtask
endmodule // swcc_core_model

`default_nettype wire

// File: tb/swcc_sleep_ctrl_bench.sv
// Self-checking bench for the sleep controller with register and wake scenarios.
// Assumes the core model stands beside the design; short restart and watchdog.
`timescale 1ns/1ps
`default_nettype none
`define CM swcc_core_model_i
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin err_count++; \
  $display("ERROR %s expected %h seen %h", n, e, a); end end

module swcc_sleep_ctrl_bench;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h0;
  wire         hreadyout, hresp, sysclk_run, core_run, wdt_osc_run, halt_exec, clr_wdt_exec;
  wire         full_reset_pulse, pc_sp_reset_pulse, resume_next_pulse, irq_service_pulse;
  wire         sleep_entered_flag, watchdog_expired_flag, stack_full, rst_pin_n, wdt_osc_pin;
  wire         clock_out_shared_pin_o, clock_out_shared_pin_oe;
  wire [31:0]  hrdata;
  wire [3:0]   irq_req, irq_en, irq_wake_vec;
  wire [7:0]   porta_pin;
  int          err_count = 0, samples_checked = 0, cycles = 0;

  swcc_sleep_ctrl #(.WDT_W(4), .RESTART(8)) swcc_sleep_ctrl_i (.hready(hreadyout), .*);
  swcc_core_model swcc_core_model_i (.*);

  always #12.5 hclk = ~hclk;

  // ****************************************
  // Bus, wake and closing tasks
  // ****************************************
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    {hsel, htrans, haddr, hwrite, hsize} <= {1'b1, 2'h2, a, w, 3'h2};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task nap;
    `CM.do_pulse(1'b1);
    repeat (3) @(posedge hclk);
    `CHK("sysclk run", 1'b0, sysclk_run)
    `CHK("core run", 1'b0, core_run)
    `CHK("sleep flag", 1'b1, sleep_entered_flag)
    `CHK("expired flag", 1'b0, watchdog_expired_flag)
  endtask

  task wake(input logic [3:0] exp);
    logic [3:0] p;
    p = 4'h0;
    repeat (200) begin
      @(posedge hclk);
      p = {full_reset_pulse, pc_sp_reset_pulse, resume_next_pulse, irq_service_pulse};
      if (|p === 1'b1) break;
    end
    `CHK("wake action", exp, p)
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task t_regs;
    bus(0, 32'h0, 32'h0);
    `CHK("cfg reset", 32'h0000_0018, rd)
    `CHK("wdt osc on", 1'b1, wdt_osc_run)
    bus(1, 32'h4, 32'hffff_ffff);
    bus(0, 32'h4, 32'h0);
    `CHK("status", 32'h0, rd)
    bus(0, 32'h100, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    `CHK("hresp okay", 1'b0, hresp)
    bus(1, 32'h100, 32'hffff_ffff);
    bus(0, 32'h0, 32'h0);
    `CHK("cfg after unmapped write", 32'h0000_0018, rd)
    for (int m = 0; m < 3; m++) begin
      bus(1, 32'h0, 32'(m));
      bus(0, 32'h0, 32'h0);
      `CHK("cfg mode", 32'(m), rd)
      `CHK("clock pin oe", m == 1, clock_out_shared_pin_oe)
      `CHK("wdt osc off", 1'b0, wdt_osc_run)
      if (m == 1) begin
        rd[0] = clock_out_shared_pin_o;
        repeat (2) @(posedge hclk);
        `CHK("clock pin divide", ~rd[0], clock_out_shared_pin_o)
      end
    end
  endtask

  task t_porta;
    bus(1, 32'h0, 32'h0000_0110);
    nap;
    `CM.porta_pin[1] <= 1'b0;
    repeat (20) @(posedge hclk);
    `CHK("disabled pin", 1'b0, sysclk_run)
    `CM.porta_pin[0] <= 1'b0;
    wake(4'b0010);
    `CM.porta_pin <= 8'hff;
  endtask

  task t_irq;
    bus(1, 32'h0, 32'h10);
    for (int i = 0; i < 3; i++) begin
      `CM.irq_req <= 4'h2;
      `CM.irq_en <= {2'h0, i != 0, i != 0};
      `CM.stack_full <= (i == 1);
      nap;
      repeat (20) @(posedge hclk);
      `CHK("pending irq", 1'b0, sysclk_run)
      `CM.irq_req <= 4'h3;
      wake(i == 2 ? 4'b0001 : 4'b0010);
      `CHK("wake vector", 4'h1, irq_wake_vec)
    end
    `CM.irq_req <= 4'h0;
  endtask

  task t_wdt;
    bus(1, 32'h0, 32'h18);
    nap;
    wake(4'b0100);
    `CHK("sleep flag", 1'b1, sleep_entered_flag)
    `CHK("expired flag", 1'b1, watchdog_expired_flag)
    `CM.do_pulse(1'b0);
    @(posedge hclk);
    `CHK("sleep flag clear", 1'b0, sleep_entered_flag)
    bus(1, 32'h0, 32'h138);
    nap;
    repeat (150) @(posedge hclk);
    `CHK("system-clocked wdt", 1'b0, sysclk_run)
    `CM.porta_pin[0] <= 1'b0;
    wake(4'b0010);
    `CM.porta_pin <= 8'hff;
  endtask

  task t_rst;
    bus(1, 32'h0, 32'h10);
    nap;
    `CM.rst_pin_n <= 1'b0;
    wake(4'b1000);
    `CM.rst_pin_n <= 1'b1;
  endtask

  // Cuts a hang short well past the few hundred cycles the run needs
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      end_of_test;
    end
  end

  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    $display("registers done");
    t_porta;
    $display("port wake done");
    t_irq;
    $display("interrupt wake done");
    t_wdt;
    $display("watchdog wake done");
    t_rst;
    $display("reset pin wake done");
    end_of_test;
  end
endmodule // swcc_sleep_ctrl_bench

`default_nettype wire
